// ===== rtl/mac_rx_filter_and_tx_kick.sv
// receive address filter, receive DMA run/stop control and transmit start command
`timescale 1ns/1ps
module mac_rx_filter_and_tx_kick #(
	parameter int FIFO_DEPTH = 32
) (
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	input  wire mac_rx_filt_pkg::reg_req_t   reg_req,
	output logic                             reg_ack,
	output logic [31:0]                      reg_rdata,
	input  wire logic                        rx_valid,
	output logic                             rx_ready,
	input  wire mac_rx_filt_pkg::rx_beat_t   rx_beat,
	output logic                             out_valid,
	input  wire logic                        out_ready,
	output mac_rx_filt_pkg::rx_word_t        out_word,
	input  wire logic                        tx_desc_avail,
	output logic                             tx_fetch,
	output mac_rx_filt_pkg::tx_state_t       tx_state,
	output mac_rx_filt_pkg::rx_state_t       rx_state
);
	localparam int WORD_W = $bits(mac_rx_filt_pkg::rx_word_t);

	//////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic hash_hit(input logic [63:0] table64, input logic [5:0] crc6);
		hash_hit = table64[crc6];
	endfunction

	function automatic logic frame_err(input mac_rx_filt_pkg::rx_beat_t b);
		frame_err = b.runt || b.oversize || b.crc_err;
	endfunction

	function automatic logic addr_accept(
		input logic [6:0]  ctl,
		input logic [47:0] da,
		input logic [5:0]  crc6,
		input logic [47:0] station,
		input logic [63:0] table64
	);
		logic bcast;
		logic mcast;
		bcast = (da == mac_rx_filt_pkg::BCAST_ADDR);
		mcast = da[mac_rx_filt_pkg::GROUP_BIT];
		addr_accept = ctl[mac_rx_filt_pkg::BIT_PROMISCUOUS]
			|| (bcast && ctl[mac_rx_filt_pkg::BIT_BROADCAST])
			|| (mcast && ctl[mac_rx_filt_pkg::BIT_ALL_MULTICAST])
			|| (!mcast && ctl[mac_rx_filt_pkg::BIT_STATION_UNICAST] && da == station)
			|| (mcast && ctl[mac_rx_filt_pkg::BIT_HASH_ENABLE] && hash_hit(table64, crc6));
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// register file

	logic [6:0]  rx_ctrl;
	logic [31:0] hash0;
	logic [31:0] hash1;
	logic [47:0] station;
	logic        tx_kick;
	logic [6:0]  next_rx_ctrl;
	logic [31:0] next_hash0;
	logic [31:0] next_hash1;
	logic [47:0] next_station;
	logic        next_tx_kick;
	logic [31:0] next_rdata;

	always_comb begin
		next_rx_ctrl = rx_ctrl;
		next_hash0   = hash0;
		next_hash1   = hash1;
		next_station = station;
		next_tx_kick = 1'b0;
		if (reg_req.wr) begin
			case (reg_req.addr)
				mac_rx_filt_pkg::OFS_RX_CTRL: next_rx_ctrl = reg_req.wdata[6:0];
				mac_rx_filt_pkg::OFS_TX_KICK: next_tx_kick = 1'b1;
				mac_rx_filt_pkg::OFS_HASH0:   next_hash0 = reg_req.wdata;
				mac_rx_filt_pkg::OFS_HASH1:   next_hash1 = reg_req.wdata;
				mac_rx_filt_pkg::OFS_STA_LO:  next_station[31:0] = reg_req.wdata;
				mac_rx_filt_pkg::OFS_STA_HI:  next_station[47:32] = reg_req.wdata[15:0];
				default: ;
			endcase
		end
		next_rdata = mac_rx_filt_pkg::WORD_RESET;
		if (reg_req.rd) begin
			case (reg_req.addr)
				mac_rx_filt_pkg::OFS_RX_CTRL: next_rdata = {25'h0, rx_ctrl};
				mac_rx_filt_pkg::OFS_HASH0:   next_rdata = hash0;
				mac_rx_filt_pkg::OFS_HASH1:   next_rdata = hash1;
				mac_rx_filt_pkg::OFS_STA_LO:  next_rdata = station[31:0];
				mac_rx_filt_pkg::OFS_STA_HI:  next_rdata = {16'h0, station[47:32]};
				mac_rx_filt_pkg::OFS_STATUS:  next_rdata = {28'h0, tx_state, rx_state};
				default:                      next_rdata = mac_rx_filt_pkg::WORD_RESET;
			endcase
		end
	end

	// the kick write is never stored, only turned into a one-cycle pulse
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_ctrl   <= mac_rx_filt_pkg::RX_CTRL_RESET;
			hash0     <= mac_rx_filt_pkg::WORD_RESET;
			hash1     <= mac_rx_filt_pkg::WORD_RESET;
			station   <= mac_rx_filt_pkg::STA_RESET;
			tx_kick   <= 1'b0;
			reg_ack   <= 1'b0;
			reg_rdata <= mac_rx_filt_pkg::WORD_RESET;
		end else begin
			rx_ctrl   <= next_rx_ctrl;
			hash0     <= next_hash0;
			hash1     <= next_hash1;
			station   <= next_station;
			tx_kick   <= next_tx_kick;
			reg_ack   <= reg_req.wr || reg_req.rd;
			reg_rdata <= next_rdata;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// receive run/stop and frame filtering

	logic                       in_frame;
	logic                       keep;
	logic                       next_in_frame;
	logic                       next_keep;
	mac_rx_filt_pkg::rx_state_t next_rx_state;
	logic                       beat_taken;
	logic                       keep_beat;
	logic                       beat_err;
	mac_rx_filt_pkg::rx_word_t  push_word;
	logic                       fifo_in_ready;

	assign beat_taken = rx_valid && fifo_in_ready;
	assign rx_ready   = fifo_in_ready;

	always_comb begin
		next_in_frame = in_frame;
		next_keep     = keep;
		keep_beat     = keep;
		if (beat_taken && rx_beat.sof) begin
			// a new frame is only admitted while running; the drain state finishes the old one
			keep_beat = (rx_state == mac_rx_filt_pkg::RX_RUNNING)
				&& addr_accept(rx_ctrl, rx_beat.da, rx_beat.hash, station, {hash1, hash0});
			next_keep     = keep_beat;
			next_in_frame = 1'b1;
		end
		if (beat_taken && rx_beat.eof) begin
			next_in_frame = 1'b0;
			next_keep     = 1'b0;
		end
		beat_err       = rx_beat.eof && frame_err(rx_beat);
		push_word.data = rx_beat.data;
		push_word.sof  = rx_beat.sof;
		push_word.eof  = rx_beat.eof;
		push_word.err  = beat_err;
		// downstream rewinds a frame marked drop; only the eof word carries the mark, earlier words may already have left the buffer
		push_word.drop = beat_err && !rx_ctrl[mac_rx_filt_pkg::BIT_PASS_ERRORS];

		next_rx_state = rx_state;
		case (rx_state)
			mac_rx_filt_pkg::RX_STOPPED: begin
				if (rx_ctrl[mac_rx_filt_pkg::BIT_RX_DMA_ENABLE]) begin
					next_rx_state = mac_rx_filt_pkg::RX_RUNNING;
				end
			end
			mac_rx_filt_pkg::RX_RUNNING: begin
				if (!rx_ctrl[mac_rx_filt_pkg::BIT_RX_DMA_ENABLE]) begin
					next_rx_state = next_in_frame ? mac_rx_filt_pkg::RX_DRAIN : mac_rx_filt_pkg::RX_STOPPED;
				end
			end
			mac_rx_filt_pkg::RX_DRAIN: begin
				if (!next_in_frame) begin
					next_rx_state = mac_rx_filt_pkg::RX_STOPPED;
				end
			end
			default: next_rx_state = mac_rx_filt_pkg::RX_STOPPED;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			in_frame <= 1'b0;
			keep     <= 1'b0;
			rx_state <= mac_rx_filt_pkg::RX_STOPPED;
		end else begin
			in_frame <= next_in_frame;
			keep     <= next_keep;
			rx_state <= next_rx_state;
		end
	end

	rx_word_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (beat_taken && keep_beat),
		.in_ready  (fifo_in_ready),
		.in_data   (push_word),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_word)
	);

	//////////////////////////////////////////////////////////////////////////////
	// transmit start command

	mac_rx_filt_pkg::tx_state_t next_tx_state;

	always_comb begin
		next_tx_state = tx_state;
		case (tx_state)
			mac_rx_filt_pkg::TX_RUNNING: begin
				if (!tx_desc_avail) begin
					next_tx_state = mac_rx_filt_pkg::TX_SUSPENDED;
				end
			end
			mac_rx_filt_pkg::TX_STOPPED,
			mac_rx_filt_pkg::TX_SUSPENDED: begin
				if (tx_kick) begin
					next_tx_state = tx_desc_avail ? mac_rx_filt_pkg::TX_RUNNING
						: mac_rx_filt_pkg::TX_SUSPENDED;
				end
			end
			default: next_tx_state = mac_rx_filt_pkg::TX_STOPPED;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_state <= mac_rx_filt_pkg::TX_STOPPED;
			tx_fetch <= 1'b0;
		end else begin
			tx_state <= next_tx_state;
			tx_fetch <= (next_tx_state == mac_rx_filt_pkg::TX_RUNNING);
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_kick_write;
		reg_req.wr && reg_req.addr == mac_rx_filt_pkg::OFS_TX_KICK;
	endsequence

	sequence s_stop_in_frame;
		rx_state == mac_rx_filt_pkg::RX_RUNNING && !rx_ctrl[mac_rx_filt_pkg::BIT_RX_DMA_ENABLE] && next_in_frame;
	endsequence

	AST_KICK_RESCAN: assert property (s_kick_write ##1 tx_desc_avail |=> tx_state == mac_rx_filt_pkg::TX_RUNNING)
		else $error("kick with descriptors did not start transmit");
	AST_KICK_SUSPEND: assert property (s_kick_write ##1 !tx_desc_avail |=> tx_state == mac_rx_filt_pkg::TX_SUSPENDED)
		else $error("kick without descriptors did not suspend transmit");
	AST_KICK_READS_ZERO: assert property (reg_req.rd && reg_req.addr == mac_rx_filt_pkg::OFS_TX_KICK |=> reg_rdata == '0)
		else $error("kick register read nonzero");
	AST_KICK_PULSE: assert property (tx_kick |=> !tx_kick || $past(reg_req.wr))
		else $error("kick pulse held without write");
	AST_CTRL_RESERVED: assert property (reg_req.rd && reg_req.addr == mac_rx_filt_pkg::OFS_RX_CTRL |=> reg_rdata[31:7] == '0)
		else $error("reserved receive control bits read nonzero");
	AST_RX_START: assert property (rx_state == mac_rx_filt_pkg::RX_STOPPED && rx_ctrl[mac_rx_filt_pkg::BIT_RX_DMA_ENABLE]
		|=> rx_state == mac_rx_filt_pkg::RX_RUNNING)
		else $error("receive did not start");
	AST_RX_DRAIN: assert property (s_stop_in_frame |=> rx_state == mac_rx_filt_pkg::RX_DRAIN)
		else $error("receive stopped inside a frame");
	// drain is checked one step at a time so the frame length needs no bound here
	AST_DRAIN_HOLD: assert property (rx_state == mac_rx_filt_pkg::RX_DRAIN && next_in_frame
		|=> rx_state == mac_rx_filt_pkg::RX_DRAIN)
		else $error("receive left drain before frame end");
	AST_DRAIN_END: assert property (rx_state == mac_rx_filt_pkg::RX_DRAIN && !next_in_frame
		|=> rx_state == mac_rx_filt_pkg::RX_STOPPED)
		else $error("receive did not stop at frame end");
	AST_RX_STOP_IDLE: assert property (rx_state == mac_rx_filt_pkg::RX_STOPPED && !rx_ctrl[mac_rx_filt_pkg::BIT_RX_DMA_ENABLE]
		|=> rx_state == mac_rx_filt_pkg::RX_STOPPED)
		else $error("stop changed a stopped receive");
	AST_NO_ADMIT_STOPPED: assert property (beat_taken && rx_beat.sof && rx_state != mac_rx_filt_pkg::RX_RUNNING
		|-> !keep_beat)
		else $error("frame admitted while not running");
	AST_PROMISC: assert property (beat_taken && rx_beat.sof && rx_state == mac_rx_filt_pkg::RX_RUNNING
		&& rx_ctrl[mac_rx_filt_pkg::BIT_PROMISCUOUS] |-> keep_beat)
		else $error("promiscuous frame rejected");
	AST_BCAST: assert property (beat_taken && rx_beat.sof && rx_state == mac_rx_filt_pkg::RX_RUNNING
		&& rx_beat.da == mac_rx_filt_pkg::BCAST_ADDR && rx_ctrl[mac_rx_filt_pkg::BIT_BROADCAST] |-> keep_beat)
		else $error("broadcast frame rejected");
	AST_ERR_DROP: assert property (beat_taken && rx_beat.eof && rx_beat.crc_err
		&& !rx_ctrl[mac_rx_filt_pkg::BIT_PASS_ERRORS] |-> push_word.drop)
		else $error("error frame not marked for drop");

endmodule // mac_rx_filter_and_tx_kick

// ===== include/mac_rx_filt_pkg.sv
// package: register map, field layout, carriers and state encodings for the rx filter and tx kick block
package mac_rx_filt_pkg;

	//////////////////////////////////////////////////////////////////////////////
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_RX_CTRL  = 8'h04;
	localparam logic [7:0] OFS_TX_KICK  = 8'h08;
	localparam logic [7:0] OFS_HASH0    = 8'h20;
	localparam logic [7:0] OFS_HASH1    = 8'h24;
	localparam logic [7:0] OFS_STA_LO   = 8'h30;
	localparam logic [7:0] OFS_STA_HI   = 8'h34;
	localparam logic [7:0] OFS_STATUS   = 8'h38;

	//////////////////////////////////////////////////////////////////////////////
	// receive control field positions and width, and the group bit of the destination address
	localparam int BIT_RX_DMA_ENABLE   = 0;
	localparam int BIT_HASH_ENABLE     = 1;
	localparam int BIT_PROMISCUOUS     = 2;
	localparam int BIT_PASS_ERRORS     = 3;
	localparam int BIT_STATION_UNICAST = 4;
	localparam int BIT_ALL_MULTICAST   = 5;
	localparam int BIT_BROADCAST       = 6;
	localparam int RX_CTRL_WIDTH       = 7;
	localparam int GROUP_BIT           = 40;

	// reset values and the broadcast address
	localparam logic [6:0]  RX_CTRL_RESET = 7'h00;
	localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
	localparam logic [47:0] STA_RESET     = 48'h0000_0000_0000;
	localparam logic [47:0] BCAST_ADDR    = 48'hFFFF_FFFF_FFFF;

	//////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [31:0] data;
		logic        sof;
		logic        eof;
		logic [47:0] da;
		logic [5:0]  hash;
		logic        runt;
		logic        oversize;
		logic        crc_err;
	} rx_beat_t;

	typedef struct packed {
		logic [31:0] data;
		logic        sof;
		logic        eof;
		logic        err;
		logic        drop;
	} rx_word_t;

	//////////////////////////////////////////////////////////////////////////////
	// state encodings
	typedef enum logic [1:0] {
		RX_STOPPED = 2'b00,
		RX_RUNNING = 2'b01,
		RX_DRAIN   = 2'b10
	} rx_state_t;

	typedef enum logic [1:0] {
		TX_STOPPED   = 2'b00,
		TX_SUSPENDED = 2'b01,
		TX_RUNNING   = 2'b10
	} tx_state_t;

endpackage

// ===== rtl/rx_word_fifo.sv
// flip-flop FIFO with registered output stage and registered not-full
`timescale 1ns/1ps
module rx_word_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             next_out_valid;
	logic [WIDTH-1:0] next_out_data;
	logic             push;
	logic             pop;

	//////////////////////////////////////////////////////////////////////////////
	// the output register refills from storage whenever it is empty or being taken
	always_comb begin
		push           = in_valid && in_ready;
		pop            = (count != '0) && (!out_valid || out_ready);
		next_wr_ptr    = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr    = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count     = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
		next_out_valid = pop ? 1'b1 : (out_valid && !out_ready);
		next_out_data  = pop ? mem[rd_ptr] : out_data;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			wr_ptr    <= next_wr_ptr;
			rd_ptr    <= next_rd_ptr;
			count     <= next_count;
			in_ready  <= (next_count != (AW+1)'(DEPTH));
			out_valid <= next_out_valid;
			out_data  <= next_out_data;
		end
	end

	// storage has no reset: contents are only read after being written
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

endmodule // rx_word_fifo

// ===== test/rx_frame_source.sv
// receive path model: offers frames beat by beat on the valid/ready stream
`timescale 1ns/1ps
module rx_frame_source (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic                 start,
	input  wire logic [47:0]          da,
	input  wire logic [5:0]           hash,
	input  wire logic [7:0]           beats,
	input  wire logic [2:0]           errs,
	input  wire logic                 gap,
	input  wire logic                 rx_ready,
	output logic                      rx_valid,
	output mac_rx_filt_pkg::rx_beat_t rx_beat,
	output logic                      busy
);
	logic [7:0] idx;

	function automatic mac_rx_filt_pkg::rx_beat_t beat(input logic [7:0] i);
		mac_rx_filt_pkg::rx_beat_t b;
		b = '0;
		b.data = {24'h000000, i};
		b.sof = (i == 8'h00);
		b.eof = (i == beats - 8'h01);
		b.da = da;
		b.hash = hash;
		{b.runt, b.oversize, b.crc_err} = b.eof ? errs : 3'h0;
		return b;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// a released stream shows the inverse of the last beat, so stale data never passes for a match
	always @(posedge clk) begin
		if (sys_rst) begin
			rx_valid <= 1'b0;
			busy <= 1'b0;
			rx_beat <= '0;
		end else if (!busy && start) begin
			busy <= 1'b1;
			idx <= 8'h00;
			rx_valid <= 1'b1;
			rx_beat <= beat(8'h00);
		end else if (busy && rx_valid && rx_ready) begin
			if (idx == beats - 8'h01) begin
				busy <= 1'b0;
				rx_valid <= 1'b0;
				rx_beat <= ~rx_beat;
			end else if (gap) begin
				idx <= idx + 8'h01;
				rx_valid <= 1'b0;
				rx_beat <= ~rx_beat;
			end else begin
				idx <= idx + 8'h01;
				rx_beat <= beat(idx + 8'h01);
			end
		end else if (busy && !rx_valid) begin
			rx_valid <= 1'b1;
			rx_beat <= beat(idx);
		end
	end
endmodule // rx_frame_source

// ===== test/mac_rx_filter_and_tx_kick_tb.sv
// self-checking bench for the receive filter and transmit start command block
`timescale 1ns/1ps
module mac_rx_filter_and_tx_kick_tb;
	localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
	localparam logic [47:0] MC = 48'h0100_5E00_0001;
	localparam logic [47:0] ST = 48'h1222_3344_5566;
	localparam logic [47:0] UC = 48'h0200_0000_0001;

	logic                       clk = 1'b0;
	logic                       sys_rst = 1'b1;
	mac_rx_filt_pkg::reg_req_t  reg_req = '0;
	logic                       reg_ack;
	logic [31:0]                reg_rdata;
	logic                       rx_valid;
	logic                       rx_ready;
	mac_rx_filt_pkg::rx_beat_t  rx_beat;
	logic                       out_valid;
	logic                       out_ready = 1'b1;
	mac_rx_filt_pkg::rx_word_t  out_word;
	logic                       tx_desc_avail = 1'b0;
	logic                       tx_fetch;
	mac_rx_filt_pkg::tx_state_t tx_state;
	mac_rx_filt_pkg::rx_state_t rx_state;
	logic                       start = 1'b0;
	logic [47:0]                da = '0;
	logic [5:0]                 hash = '0;
	logic [7:0]                 beats = 8'h01;
	logic [2:0]                 errs = '0;
	logic                       gap = 1'b0;
	logic                       busy;
	int                         failures = 0;
	int                         n_tests = 0;
	mac_rx_filt_pkg::rx_word_t  got[$];
	logic [31:0]                d;

	always #25 clk = ~clk;

	mac_rx_filter_and_tx_kick #(.FIFO_DEPTH(32)) uut (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
		.reg_ack(reg_ack), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_beat(rx_beat),
		.out_valid(out_valid), .out_ready(out_ready), .out_word(out_word), .tx_desc_avail(tx_desc_avail),
		.tx_fetch(tx_fetch), .tx_state(tx_state), .rx_state(rx_state));

	rx_frame_source src (.clk(clk), .sys_rst(sys_rst), .start(start), .da(da), .hash(hash), .beats(beats),
		.errs(errs), .gap(gap), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_beat(rx_beat), .busy(busy));

	always @(posedge clk) begin
		if (!sys_rst && out_valid && out_ready) begin
			got.push_back(out_word);
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk);
		reg_req <= '0;
		#1;
		check("write ack", reg_ack, 1);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		reg_req <= '0;
		#1;
		v = reg_rdata;
	endtask

	task automatic launch(input logic [47:0] a, input logic [5:0] h, input logic [7:0] n, input logic [2:0] e,
		input logic g);
		@(posedge clk);
		start <= 1'b1;
		da <= a;
		hash <= h;
		beats <= n;
		errs <= e;
		gap <= g;
		@(posedge clk);
		start <= 1'b0;
	endtask

	// bounded wait for the model to finish, then time for the words to leave the buffer
	task automatic finish_frame();
		#1;
		for (int i = 0; i < 400 && busy; i++) @(posedge clk);
		repeat (6) @(posedge clk);
	endtask

	task automatic filt(input logic [6:0] c, input logic [47:0] a, input logic [5:0] h, input int n);
		wr(mac_rx_filt_pkg::OFS_RX_CTRL, {25'h0, c});
		got.delete();
		launch(a, h, 8'h01, 3'h0, 1'b0);
		finish_frame();
		check("frames out", 64'(got.size()), 64'(n));
	endtask

	//////////////////////////////////////////////////////////////////////////////
	task automatic test_regs();
		check("rx state reset", rx_state, mac_rx_filt_pkg::RX_STOPPED);
		check("tx state reset", tx_state, mac_rx_filt_pkg::TX_STOPPED);
		rd(mac_rx_filt_pkg::OFS_RX_CTRL, d);
		check("rx ctrl reset", d, 0);
		rd(mac_rx_filt_pkg::OFS_TX_KICK, d);
		check("kick reset", d, 0);
		rd(8'h3C, d);
		check("unmapped", d, 0);
		wr(mac_rx_filt_pkg::OFS_RX_CTRL, 32'hFFFF_FFFF);
		rd(mac_rx_filt_pkg::OFS_RX_CTRL, d);
		check("rx ctrl mask", d, 32'h0000_007F);
		wr(mac_rx_filt_pkg::OFS_RX_CTRL, 32'h0000_0000);
	endtask

	task automatic test_tx_kick();
		wr(mac_rx_filt_pkg::OFS_TX_KICK, 32'hDEAD_BEEF);
		@(posedge clk);
		#1;
		check("tx idle kick", {tx_fetch, tx_state}, {1'b0, mac_rx_filt_pkg::TX_SUSPENDED});
		rd(mac_rx_filt_pkg::OFS_TX_KICK, d);
		check("kick readback", d, 0);
		@(posedge clk);
		tx_desc_avail <= 1'b1;
		wr(mac_rx_filt_pkg::OFS_TX_KICK, 32'h0000_0000);
		@(posedge clk);
		#1;
		check("tx kick run", {tx_fetch, tx_state}, {1'b1, mac_rx_filt_pkg::TX_RUNNING});
		@(posedge clk);
		tx_desc_avail <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check("tx ran out", {tx_fetch, tx_state}, {1'b0, mac_rx_filt_pkg::TX_SUSPENDED});
	endtask

	task automatic test_filter();
		wr(mac_rx_filt_pkg::OFS_STA_LO, 32'h3344_5566);
		wr(mac_rx_filt_pkg::OFS_STA_HI, 32'h0000_1222);
		wr(mac_rx_filt_pkg::OFS_HASH1, 32'h0000_0020);
		filt(7'h41, BC, 6'h00, 1);
		filt(7'h01, BC, 6'h00, 0);
		filt(7'h21, BC, 6'h00, 1);
		filt(7'h21, MC, 6'h00, 1);
		filt(7'h11, ST, 6'h00, 1);
		filt(7'h11, UC, 6'h00, 0);
		filt(7'h05, UC, 6'h00, 1);
		filt(7'h03, MC, 6'h25, 1);
		filt(7'h03, MC, 6'h05, 0);
		filt(7'h03, UC, 6'h25, 0);
	endtask

	task automatic test_errors();
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 3; k++) begin
				wr(mac_rx_filt_pkg::OFS_RX_CTRL, 32'h41 | (p << 3));
				got.delete();
				launch(BC, 6'h00, 8'h01, 3'b100 >> k, 1'b0);
				finish_frame();
				check("error frame out", 64'(got.size()), 1);
				if (got.size() == 1) begin
					check("error flag", got[0].err, 1);
					check("drop flag", got[0].drop, p == 0);
				end
			end
		end
	endtask

	// stall the consumer until the buffer refuses, then drain and compare every word
	task automatic test_fifo();
		wr(mac_rx_filt_pkg::OFS_RX_CTRL, 32'h41);
		got.delete();
		@(posedge clk);
		out_ready <= 1'b0;
		launch(BC, 6'h00, 8'd40, 3'h0, 1'b0);
		repeat (60) @(posedge clk);
		#1;
		check("buffer full", rx_ready, 0);
		@(posedge clk);
		out_ready <= 1'b1;
		finish_frame();
		// the buffer is still nearly full when the last beat enters
		repeat (40) @(posedge clk);
		check("words drained", 64'(got.size()), 40);
		for (int i = 0; i < got.size(); i++) begin
			check("word", {got[i].sof, got[i].eof, got[i].data}, {i == 0, i == 39, 32'(i)});
		end
	endtask

	task automatic test_stop();
		wr(mac_rx_filt_pkg::OFS_RX_CTRL, 32'h41);
		@(posedge clk);
		#1;
		check("running", rx_state, mac_rx_filt_pkg::RX_RUNNING);
		got.delete();
		launch(BC, 6'h00, 8'h04, 3'h0, 1'b1);
		wr(mac_rx_filt_pkg::OFS_RX_CTRL, 32'h40);
		@(posedge clk);
		#1;
		check("draining", rx_state, mac_rx_filt_pkg::RX_DRAIN);
		finish_frame();
		check("stopped", rx_state, mac_rx_filt_pkg::RX_STOPPED);
		check("frame finished", 64'(got.size()), 4);
		launch(BC, 6'h00, 8'h01, 3'h0, 1'b0);
		finish_frame();
		check("no rx when stopped", 64'(got.size()), 4);
		wr(mac_rx_filt_pkg::OFS_RX_CTRL, 32'h40);
		@(posedge clk);
		#1;
		check("stop when stopped", rx_state, mac_rx_filt_pkg::RX_STOPPED);
		rd(mac_rx_filt_pkg::OFS_STATUS, d);
		check("status", d, {28'h0, mac_rx_filt_pkg::TX_SUSPENDED, mac_rx_filt_pkg::RX_STOPPED});
	endtask

	//////////////////////////////////////////////////////////////////////////////
	initial begin
		#(50 * 20000);
		failures++;
		end_of_test();
	end

	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		test_regs();
		test_tx_kick();
		test_filter();
		test_errors();
		test_fifo();
		test_stop();
		end_of_test();
	end
endmodule // mac_rx_filter_and_tx_kick_tb
